// file: rtl/flash_pkg.sv
package flash_pkg;
    // Register offsets
    localparam logic [2:0] OFS_CONTROL = 3'h0;
    localparam logic [2:0] OFS_UNLOCK = 3'h1;
    localparam logic [2:0] OFS_ADDR_LO = 3'h2;
    localparam logic [2:0] OFS_ADDR_HI = 3'h3;
    localparam logic [2:0] OFS_DATA_LO = 3'h4;
    localparam logic [2:0] OFS_DATA_HI = 3'h5;
    // Control register fields
    localparam int BIT_RD = 0;
    localparam int BIT_WR = 1;
    localparam int BIT_WRITE_ENABLE_BIT = 2;
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // Array shape
    localparam int ADDR_W = 10;
    localparam int WORD_W = 14;
    localparam int WORDS = 1024;
    localparam int BLOCK_WORDS = 4;
    localparam int ERASE_WORDS = 16;
    localparam logic [1:0] LAST_SLOT = 2'h3;
    localparam logic [13:0] ERASED_WORD = 14'h3fff;
    // Write protect fuse codes, upper bound (exclusive) of protected area
    localparam logic [1:0] WP_NONE = 2'h3;
    localparam logic [1:0] WP_QUARTER = 2'h2;
    localparam logic [1:0] WP_HALF = 2'h1;
    localparam logic [10:0] WP_QUARTER_TOP = 11'h100;
    localparam logic [10:0] WP_HALF_TOP = 11'h200;
    localparam logic [10:0] WP_ALL_TOP = 11'h400;
    // Timing
    localparam longint CLK_HZ = 50000000;
    localparam longint COMMIT_MS = 4;
    localparam longint POWER_UP_DELAY_TIMER_MS = 64;
    localparam int COMMIT_CYCLES = int'((CLK_HZ * COMMIT_MS) / 1000);
    localparam int POWER_UP_DELAY_TIMER_CYCLES = int'((CLK_HZ * POWER_UP_DELAY_TIMER_MS) / 1000);
    localparam int SETUP_CYCLES = 2;
    localparam int CNT_W = 22;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    typedef struct packed {
        logic [9:0] addr;
        logic [13:0] data;
        logic wr;
    } serial_req_t;
endpackage

// file: rtl/program_flash_self_access.sv
// Functional notes
// - Array read happens two cycles after read start; that instruction discarded.
// - Read data lands in data registers next cycle and holds.
// - Serial word writes accepted only outside write-protected segments.
// - Blocks are four words aligned on low address bits 00.
// - Commit erases aligned sixteen words, programs four, never crosses block.
// - Words written in order 00..11, each with own unlock and start.
// - First three words only latch into buffer, completing at once.
// - Write start at slot 11 erases the aligned sixteen words and programs buffer.
// - Two setup cycles after write start; software places two no-ops.
// - Core stalls about 4 ms during commit, clocks keep running.
// - Execution resumes at third instruction after write start.
// - Write enable clears at reset; no writes during 64 ms timer.
// - Write needs write enable set and completed unlock sequence.
// - Code protection does not scramble or block self access.
// - Write protection blocks only the serial programming port.
// - Start bits set-only by software, cleared by hardware on completion.
// - Self-access program and erase only while write enable is set.
// - Unlock register has no storage and reads zero.
// - Address registers form 10-bit address, data registers 14-bit word.
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module program_flash_self_access #(
    parameter int COMMIT_CYCLES = flash_pkg::COMMIT_CYCLES,
    parameter int POWER_UP_DELAY_TIMER_CYCLES = flash_pkg::POWER_UP_DELAY_TIMER_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire flash_pkg::bus_req_t bus_req,
    output logic [7:0] rd_data,
    input wire logic [1:0] write_protect_fuses,
    input wire logic code_protect_fuse,
    input wire flash_pkg::serial_req_t serial_req,
    output logic serial_refused,
    output logic discard_instr,
    output logic core_stall,
    output logic timer_running
);
    typedef enum logic [1:0] {KEY_IDLE, KEY_GOT_FIRST, KEY_ARMED} key_state_t;
    typedef enum logic [2:0] {SEQ_IDLE, SEQ_READ_WAIT, SEQ_READ_ACCESS, SEQ_SETUP, SEQ_COMMIT} seq_state_t;

    logic [13:0] flash_mem [0:flash_pkg::WORDS-1];
    logic [13:0] buffer_reg [0:flash_pkg::BLOCK_WORDS-1];
    logic [7:0] addr_lo_reg;
    logic [1:0] addr_hi_reg;
    logic [7:0] data_lo_reg;
    logic [5:0] data_hi_reg;
    logic write_enable_bit_reg;
    logic rd_bit_reg;
    logic wr_bit_reg;
    logic commit_pending_reg;
    key_state_t key_reg;
    seq_state_t seq_reg;
    logic [flash_pkg::CNT_W-1:0] cnt_reg;
    logic [flash_pkg::CNT_W-1:0] power_up_delay_timer_cnt_reg;

    logic [9:0] word_addr;
    logic [9:0] block_base;
    logic [9:0] erase_base;
    logic [10:0] wp_top;
    logic target_protected;
    logic ctrl_write;
    logic read_start;
    logic write_start;
    logic seq_busy;
    logic [13:0] wdata_word;
    logic wr_unlock;
    logic wr_addr_lo;
    logic wr_addr_hi;
    logic wr_data_lo;
    logic wr_data_hi;
    logic [1:0] block_slot;
    logic key_armed;
    logic timer_done;
    logic setup_done;
    logic commit_done;
    logic array_write_ok;
    logic serial_write_ok;
    logic [7:0] rd_mux;

    assign word_addr = {addr_hi_reg, addr_lo_reg};
    assign wdata_word = {data_hi_reg, data_lo_reg};
    assign block_base = {word_addr[9:2], 2'h0};
    assign erase_base = {word_addr[9:4], 4'h0};
    assign seq_busy = (seq_reg != SEQ_IDLE);
    assign ctrl_write = bus_req.wr && (bus_req.addr == flash_pkg::OFS_CONTROL);
    assign wr_unlock = bus_req.wr && (bus_req.addr == flash_pkg::OFS_UNLOCK);
    assign wr_addr_lo = bus_req.wr && (bus_req.addr == flash_pkg::OFS_ADDR_LO);
    assign wr_addr_hi = bus_req.wr && (bus_req.addr == flash_pkg::OFS_ADDR_HI);
    assign wr_data_lo = bus_req.wr && (bus_req.addr == flash_pkg::OFS_DATA_LO);
    assign wr_data_hi = bus_req.wr && (bus_req.addr == flash_pkg::OFS_DATA_HI);
    assign block_slot = addr_lo_reg[1:0];
    assign key_armed = (key_reg == KEY_ARMED);
    // writes wait until the delay timer has expired
    assign timer_done = (power_up_delay_timer_cnt_reg == '0);
    // Last setup cycle and last commit cycle
    assign setup_done = (seq_reg == SEQ_SETUP) && (cnt_reg == '0);
    assign commit_done = (seq_reg == SEQ_COMMIT) && (cnt_reg == '0);
    // commit changes the array only while write enable still holds; serial port writes do not need it
    assign array_write_ok = commit_done && write_enable_bit_reg;
    // serial writes need an unprotected word and an idle sequencer
    assign serial_write_ok = serial_req.wr && !target_protected && !seq_busy && !code_protect_fuse;

    always_comb begin
        unique case (write_protect_fuses)
            flash_pkg::WP_NONE: wp_top = 11'h000;
            flash_pkg::WP_QUARTER: wp_top = flash_pkg::WP_QUARTER_TOP;
            flash_pkg::WP_HALF: wp_top = flash_pkg::WP_HALF_TOP;
            default: wp_top = flash_pkg::WP_ALL_TOP;
        endcase
    end
    // applies to the serial port; self access ignores it
    assign target_protected = ({1'b0, serial_req.addr} < wp_top);

    assign read_start = ctrl_write && bus_req.wdata[flash_pkg::BIT_RD] && !seq_busy;
    // write enable, unlock and timer all needed
    assign write_start = ctrl_write && bus_req.wdata[flash_pkg::BIT_WR] && !seq_busy
        && !bus_req.wdata[flash_pkg::BIT_RD] && write_enable_bit_reg && key_armed && timer_done;

    always_ff @(posedge clk) begin
        if (rst) begin
            power_up_delay_timer_cnt_reg <= flash_pkg::CNT_W'(POWER_UP_DELAY_TIMER_CYCLES);
        end else if (power_up_delay_timer_cnt_reg != '0) begin
            power_up_delay_timer_cnt_reg <= power_up_delay_timer_cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            timer_running <= 1'b1;
        end else begin
            timer_running <= (power_up_delay_timer_cnt_reg > 1);
        end
    end

    // unlock tracker, only consecutive writes count
    always_ff @(posedge clk) begin
        if (rst) begin
            key_reg <= KEY_IDLE;
        end else if (bus_req.wr) begin
            if (wr_unlock && bus_req.wdata == flash_pkg::KEY_FIRST) begin
                key_reg <= KEY_GOT_FIRST;
            end else if (key_reg == KEY_GOT_FIRST && wr_unlock && bus_req.wdata == flash_pkg::KEY_SECOND) begin
                key_reg <= KEY_ARMED;
            end else begin
                // The arming is spent by any other write, the start included
                key_reg <= KEY_IDLE;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            write_enable_bit_reg <= 1'b0;
        end else if (ctrl_write) begin
            write_enable_bit_reg <= bus_req.wdata[flash_pkg::BIT_WRITE_ENABLE_BIT];
        end
    end

    // Address registers
    always_ff @(posedge clk) begin
        if (rst) begin
            addr_lo_reg <= flash_pkg::RESET_BYTE;
            addr_hi_reg <= 2'h0;
        end else begin
            if (wr_addr_lo) begin
                addr_lo_reg <= bus_req.wdata;
            end
            if (wr_addr_hi) begin
                addr_hi_reg <= bus_req.wdata[1:0];
            end
        end
    end

    // Sequencer
    always_ff @(posedge clk) begin
        if (rst) begin
            seq_reg <= SEQ_IDLE;
            cnt_reg <= '0;
            commit_pending_reg <= 1'b0;
        end else begin
            unique case (seq_reg)
                SEQ_IDLE: begin
                    if (read_start) begin
                        seq_reg <= SEQ_READ_WAIT;
                    end else if (write_start) begin
                        // two setup cycles follow the start
                        seq_reg <= SEQ_SETUP;
                        cnt_reg <= flash_pkg::CNT_W'(flash_pkg::SETUP_CYCLES - 1);
                        commit_pending_reg <= (block_slot == flash_pkg::LAST_SLOT);
                    end
                end
                SEQ_READ_WAIT: seq_reg <= SEQ_READ_ACCESS;
                SEQ_READ_ACCESS: seq_reg <= SEQ_IDLE;
                SEQ_SETUP: begin
                    if (cnt_reg != '0) begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end else if (commit_pending_reg) begin
                        seq_reg <= SEQ_COMMIT;
                        cnt_reg <= flash_pkg::CNT_W'(COMMIT_CYCLES - 1);
                    end else begin
                        // buffered words finish right after setup
                        seq_reg <= SEQ_IDLE;
                    end
                end
                SEQ_COMMIT: begin
                    if (cnt_reg != '0) begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end else begin
                        seq_reg <= SEQ_IDLE;
                        commit_pending_reg <= 1'b0;
                    end
                end
                default: seq_reg <= SEQ_IDLE;
            endcase
        end
    end

    // start bits set by software, cleared by hardware
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_bit_reg <= 1'b0;
        end else if (read_start) begin
            rd_bit_reg <= 1'b1;
        end else if (seq_reg == SEQ_READ_ACCESS) begin
            rd_bit_reg <= 1'b0;
        end
    end

    // write bit holds until the operation ends
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_bit_reg <= 1'b0;
        end else if (write_start) begin
            wr_bit_reg <= 1'b1;
        end else if ((setup_done && !commit_pending_reg) || commit_done) begin
            wr_bit_reg <= 1'b0;
        end
    end

    // discard the instruction in the access cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            discard_instr <= 1'b0;
        end else begin
            discard_instr <= (seq_reg == SEQ_READ_WAIT);
        end
    end

    // core stall during erase and program
    always_ff @(posedge clk) begin
        if (rst) begin
            core_stall <= 1'b0;
        end else if (setup_done && commit_pending_reg) begin
            core_stall <= 1'b1;
        end else if (commit_done) begin
            core_stall <= 1'b0;
        end
    end

    // data registers hold read data until next read or user write
    always_ff @(posedge clk) begin
        if (rst) begin
            data_lo_reg <= flash_pkg::RESET_BYTE;
            data_hi_reg <= 6'h00;
        end else if (seq_reg == SEQ_READ_ACCESS) begin
            // plain contents whatever the code protection
            data_lo_reg <= flash_mem[word_addr][7:0];
            data_hi_reg <= flash_mem[word_addr][13:8];
        end else begin
            if (wr_data_lo) begin
                data_lo_reg <= bus_req.wdata;
            end
            if (wr_data_hi) begin
                data_hi_reg <= bus_req.wdata[5:0];
            end
        end
    end

    // Buffer slots, one per word of the block
    genvar slot;
    generate
        for (slot = 0; slot < flash_pkg::BLOCK_WORDS; slot++) begin : g_buf
            always_ff @(posedge clk) begin
                if (rst) begin
                    buffer_reg[slot] <= flash_pkg::ERASED_WORD;
                // the low address bits pick the slot
                end else if (write_start && block_slot == 2'(slot)) begin
                    buffer_reg[slot] <= wdata_word;
                end
            end
        end
    endgenerate

    // Array update; flash content is not touched by reset
    always_ff @(posedge clk) begin
        // no self-access erase or program without write enable
        if (array_write_ok) begin
            // erase then program inside the aligned group
            for (int i = 0; i < flash_pkg::ERASE_WORDS; i++) begin
                flash_mem[erase_base + 10'(i)] <= flash_pkg::ERASED_WORD;
            end
            for (int j = 0; j < flash_pkg::BLOCK_WORDS; j++) begin
                flash_mem[block_base + 10'(j)] <= buffer_reg[j];
            end
        // serial port writes only unprotected words
        end else if (serial_write_ok) begin
            flash_mem[serial_req.addr] <= serial_req.data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            serial_refused <= 1'b0;
        end else begin
            serial_refused <= serial_req.wr && !serial_write_ok;
        end
    end

    // Register read selection
    always_comb begin
        rd_mux = 8'h00;
        unique case (bus_req.addr)
            flash_pkg::OFS_CONTROL: rd_mux = {5'h00, write_enable_bit_reg, wr_bit_reg, rd_bit_reg};
            flash_pkg::OFS_UNLOCK: rd_mux = 8'h00;
            flash_pkg::OFS_ADDR_LO: rd_mux = addr_lo_reg;
            flash_pkg::OFS_ADDR_HI: rd_mux = {6'h00, addr_hi_reg};
            flash_pkg::OFS_DATA_LO: rd_mux = data_lo_reg;
            flash_pkg::OFS_DATA_HI: rd_mux = {2'h0, data_hi_reg};
            default: rd_mux = 8'h00;
        endcase
    end

    // Read data, one cycle after the strobe; zero otherwise so stale values never linger
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_data <= flash_pkg::RESET_BYTE;
        end else if (bus_req.rd) begin
            rd_data <= rd_mux;
        end else begin
            rd_data <= 8'h00;
        end
    end
endmodule // program_flash_self_access

// file: verification/flash_self_access_sva.sv
`timescale 1ns/1ps
module flash_self_access_sva #(
    parameter int COMMIT_CYCLES = 20,
    parameter int POWER_UP_DELAY_TIMER_CYCLES = 10
) (
    input wire logic clk,
    input wire logic rst,
    input wire flash_pkg::bus_req_t bus_req,
    input wire logic [7:0] rd_data,
    input wire logic [1:0] write_protect_fuses,
    input wire logic code_protect_fuse,
    input wire flash_pkg::serial_req_t serial_req,
    input wire logic serial_refused,
    input wire logic discard_instr,
    input wire logic core_stall,
    input wire logic timer_running
);
    logic ctl_wr;
    int stall_cnt;
    int pw_cnt;
    assign ctl_wr = bus_req.wr && (bus_req.addr == flash_pkg::OFS_CONTROL);
    // Counts stall length so a stuck or short commit shows up
    always_ff @(posedge clk) begin
        if (rst || !core_stall) begin
            stall_cnt <= 0;
        end else begin
            stall_cnt <= stall_cnt + 1;
        end
    end
    // Saturates so a long run never wraps
    always_ff @(posedge clk) begin
        if (rst) begin
            pw_cnt <= 0;
        end else if (pw_cnt < 1000) begin
            pw_cnt <= pw_cnt + 1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_read_discard_slot: assert property (
        discard_instr |-> $past(ctl_wr && bus_req.wdata[flash_pkg::BIT_RD], 2)) else $error("discard without read");
    chk_rd_data_quiet: assert property (
        rd_data != 8'h00 |-> $past(bus_req.rd)) else $error("read data outside answer cycle");
    chk_unlock_reads_zero: assert property (
        bus_req.rd && bus_req.addr == flash_pkg::OFS_UNLOCK |=> rd_data == 8'h00) else $error("unlock not zero");
    chk_stall_cause: assert property (
        $rose(core_stall) |-> $past(ctl_wr && bus_req.wdata[flash_pkg::BIT_WR], 3)) else $error("stall start");
    chk_stall_length: assert property (
        $fell(core_stall) |-> stall_cnt == COMMIT_CYCLES) else $error("commit length wrong");
    chk_stall_bound: assert property (
        core_stall |-> stall_cnt < COMMIT_CYCLES) else $error("commit overruns");
    chk_timer_hold: assert property (
        $fell(rst) |-> timer_running [*8]) else $error("delay timer ended early");
    chk_timer_ends: assert property (
        pw_cnt > POWER_UP_DELAY_TIMER_CYCLES |-> !timer_running) else $error("delay timer never ends");
    chk_no_early_commit: assert property (
        core_stall |-> !timer_running) else $error("commit during delay timer");
    chk_serial_cause: assert property (
        serial_refused |-> $past(serial_req.wr)) else $error("refusal without request");
    chk_serial_guard: assert property (
        serial_req.wr && write_protect_fuses == 2'h0 |=> serial_refused) else $error("protected serial write");
endmodule // flash_self_access_sva

bind program_flash_self_access flash_self_access_sva #(
    .COMMIT_CYCLES(COMMIT_CYCLES), .POWER_UP_DELAY_TIMER_CYCLES(POWER_UP_DELAY_TIMER_CYCLES)
) sva_inst (.clk(clk), .rst(rst), .bus_req(bus_req), .rd_data(rd_data),
    .write_protect_fuses(write_protect_fuses), .code_protect_fuse(code_protect_fuse),
    .serial_req(serial_req), .serial_refused(serial_refused), .discard_instr(discard_instr),
    .core_stall(core_stall), .timer_running(timer_running));

// file: verification/test_program_flash_self_access.sv
`timescale 1ns/1ps
module test_program_flash_self_access;
    localparam int COMMIT = 20;
    logic clk = 1'b0;
    logic rst = 1'b1;
    flash_pkg::bus_req_t bus_req = '0;
    logic [1:0] write_protect_fuses = 2'h3;
    logic code_protect_fuse = 1'b0;
    flash_pkg::serial_req_t serial_req = '0;
    logic [7:0] rd_data;
    logic serial_refused;
    logic discard_instr;
    logic core_stall;
    logic timer_running;
    int mismatches = 0;
    int compares = 0;

    program_flash_self_access #(.COMMIT_CYCLES(COMMIT), .POWER_UP_DELAY_TIMER_CYCLES(10)) dut (
        .clk(clk), .rst(rst), .bus_req(bus_req), .rd_data(rd_data),
        .write_protect_fuses(write_protect_fuses), .code_protect_fuse(code_protect_fuse),
        .serial_req(serial_req), .serial_refused(serial_refused), .discard_instr(discard_instr),
        .core_stall(core_stall), .timer_running(timer_running));

    initial begin
        forever #10 clk = ~clk;
    end

    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One strobe cycle, then idle; read data sampled in the answer cycle
    task automatic access(input logic [2:0] a, input logic [7:0] d, input logic w, output logic [7:0] q);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge clk);
        bus_req <= '0;
        #1;
        q = rd_data;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        logic [7:0] q;
        access(a, d, 1'b1, q);
    endtask

    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] q;
        access(a, 8'h00, 1'b0, q);
        check(q, exp);
    endtask

    task automatic wait_stall(input logic v);
        int n;
        n = 0;
        while (core_stall !== v && n < COMMIT + 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(core_stall, v);
    endtask

    task automatic put_word(input logic [9:0] a, input logic [13:0] d, input logic [7:0] key2);
        wr(flash_pkg::OFS_ADDR_LO, a[7:0]);
        wr(flash_pkg::OFS_ADDR_HI, {6'h0, a[9:8]});
        wr(flash_pkg::OFS_DATA_LO, d[7:0]);
        wr(flash_pkg::OFS_DATA_HI, {2'h0, d[13:8]});
        wr(flash_pkg::OFS_CONTROL, 8'h04);
        wr(flash_pkg::OFS_UNLOCK, 8'h55);
        wr(flash_pkg::OFS_UNLOCK, key2);
        wr(flash_pkg::OFS_CONTROL, 8'h06);
        if (a[1:0] == 2'h3 && key2 == 8'haa) begin
            wait_stall(1'b1);
            wait_stall(1'b0);
        end
        @(posedge clk);
        rd_chk(flash_pkg::OFS_CONTROL, 8'h04);
    endtask

    task automatic read_word(input logic [9:0] a, input logic [13:0] exp);
        logic [7:0] lo;
        logic [7:0] hi;
        wr(flash_pkg::OFS_ADDR_LO, a[7:0]);
        wr(flash_pkg::OFS_ADDR_HI, {6'h0, a[9:8]});
        wr(flash_pkg::OFS_CONTROL, 8'h01);
        @(posedge clk);
        #1;
        check(discard_instr, 1'b1);
        access(flash_pkg::OFS_DATA_LO, 8'h00, 1'b0, lo);
        access(flash_pkg::OFS_DATA_HI, 8'h00, 1'b0, hi);
        check({hi[5:0], lo}, exp);
        rd_chk(flash_pkg::OFS_CONTROL, 8'h00);
    endtask

    task automatic serial(input logic [9:0] a, input logic [13:0] d, input logic exp);
        @(posedge clk);
        serial_req <= '{addr: a, data: d, wr: 1'b1};
        @(posedge clk);
        serial_req <= '0;
        #1;
        check(serial_refused, exp);
    endtask

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        check(timer_running, 1'b1);
        wr(flash_pkg::OFS_CONTROL, 8'h04);
        wr(flash_pkg::OFS_UNLOCK, 8'h55);
        wr(flash_pkg::OFS_UNLOCK, 8'haa);
        wr(flash_pkg::OFS_CONTROL, 8'h06);
        @(posedge clk);
        rd_chk(flash_pkg::OFS_CONTROL, 8'h04);
        for (int i = 1; i < 7; i++) rd_chk(3'(i), 8'h00);
        wr(flash_pkg::OFS_ADDR_HI, 8'hff);
        rd_chk(flash_pkg::OFS_ADDR_HI, 8'h03);
        wr(flash_pkg::OFS_DATA_HI, 8'hff);
        rd_chk(flash_pkg::OFS_DATA_HI, 8'h3f);
        wr(flash_pkg::OFS_UNLOCK, 8'h55);
        rd_chk(flash_pkg::OFS_UNLOCK, 8'h00);
        check(timer_running, 1'b0);
        wr(flash_pkg::OFS_CONTROL, 8'h00);
        wr(flash_pkg::OFS_UNLOCK, 8'h55);
        wr(flash_pkg::OFS_UNLOCK, 8'haa);
        wr(flash_pkg::OFS_CONTROL, 8'h02);
        rd_chk(flash_pkg::OFS_CONTROL, 8'h00);
        put_word(10'h010, 14'h1111, 8'h5a);
        @(posedge clk);
        write_protect_fuses <= 2'h0;
        code_protect_fuse <= 1'b1;
        for (int i = 0; i < 4; i++) put_word(10'h010 + 10'(i), 14'h2a50 + 14'(i), 8'haa);
        for (int i = 0; i < 4; i++) read_word(10'h010 + 10'(i), 14'h2a50 + 14'(i));
        read_word(10'h01f, flash_pkg::ERASED_WORD);
        serial(10'h020, 14'h0123, 1'b1);
        @(posedge clk);
        write_protect_fuses <= 2'h3;
        code_protect_fuse <= 1'b0;
        serial(10'h020, 14'h0123, 1'b0);
        read_word(10'h020, 14'h0123);
        summarize();
    end

    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        summarize();
    end
endmodule // test_program_flash_self_access
